// ---- rtl/pcg_pkg.sv ----
// Shared constants and types of the PLL clock generator control block.
package pcg_pkg;
  // Register indices; the APB byte address is four times the index.
  localparam logic [7:0] IDX_LOOP_MULT = 8'h38;
  localparam logic [7:0] IDX_REF_DIV = 8'h39;
  localparam logic [7:0] IDX_FLAGS = 8'h3b;
  localparam logic [7:0] IDX_PLL_CTRL = 8'h3c;
  localparam logic [7:0] IDX_CLK_SEL = 8'h3d;
  localparam logic [7:0] IDX_SLOW_DIV = 8'h3e;
  // Field positions of pll_control.
  localparam int CTL_LOCK_IE = 7;
  localparam int CTL_PLL_ON = 6;
  localparam int CTL_AUTO = 5;
  localparam int CTL_ACQ = 4;
  localparam int CTL_PSTOP = 2;
  localparam int CTL_LIMP_IE = 1;
  localparam int CTL_NO_LIMP = 0;
  // Field positions of clock_source_select.
  localparam int SEL_BUS_CLOCK_PLL_SELECT = 7;
  localparam int SEL_BUS_CLOCK_SLOW_SELECT = 6;
  localparam int SEL_MCS = 0;
  // Field positions of pll_flags.
  localparam int FLG_LOCK_CHG = 7;
  localparam int FLG_LOCK = 6;
  localparam int FLG_LIMP_CHG = 1;
  localparam int FLG_LIMP = 0;
  // Reset values.
  localparam logic [7:0] PLL_CTRL_RST = 8'h60;
  localparam logic [7:0] CLK_SEL_RST = 8'h00;
  localparam logic [5:0] SLOW_DIV_RST = 6'h00;
  localparam logic [7:0] LOOP_MULT_RST = 8'h00;
  localparam logic [7:0] REF_DIV_RST = 8'h00;
  // Counts in slow-derived clock cycles.
  localparam logic [12:0] EXIT_LONG_SLOW_DERIVED_CLOCK = 13'h1000;
  localparam logic [12:0] EXIT_SHORT_SLOW_DERIVED_CLOCK = 13'h0010;
  localparam logic [12:0] LIMP_CHECK_SLOW_DERIVED_CLOCK = 13'h1000;
  // System clock source and stop-exit states.
  typedef enum logic [1:0] {PCG_SRC_OSC, PCG_SRC_SLOW, PCG_SRC_PLL} pcg_src_t;
  typedef enum logic [1:0] {PCG_EX_RUN, PCG_EX_STOP, PCG_EX_DELAY} pcg_exit_t;
endpackage : pcg_pkg

// ---- rtl/pcg_if.sv ----
// Internal carrier between the control top, slow divider and exit control.
`timescale 1ns/100ps
interface pcg_if;
  logic [5:0] slow_div;
  logic slow_level;
  logic slow_derived_clock_level;
  logic slow_derived_clock_tick;
  logic stop_req;
  logic pstop_en;
  logic wake;
  logic no_limp;
  logic clock_monitor_enable;
  logic dly;
  logic held;
  logic osc_run;
  logic limp_enter;
  logic cm_reset;
  modport div (input slow_div, output slow_level, slow_derived_clock_level, slow_derived_clock_tick);
  modport exitc (input stop_req, pstop_en, wake, no_limp, clock_monitor_enable, dly,
    slow_derived_clock_tick, output held, osc_run, limp_enter, cm_reset);
  modport top (output slow_div, stop_req, pstop_en, wake, no_limp, clock_monitor_enable, dly,
    input slow_level, slow_derived_clock_level, slow_derived_clock_tick, held, osc_run, limp_enter,
    cm_reset);
endinterface : pcg_if

// ---- rtl/pcg_slow_div.sv ----
// Programmable slow clock divider and slow-derived clock generator.
`timescale 1ns/100ps
module pcg_slow_div
  import pcg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  pcg_if.div d
);
  logic [5:0] cnt_q, cnt_d;
  logic slow_q, slow_d;
  logic slow_derived_clock_q, slow_derived_clock_d;
  logic tick_q, tick_d;

  // A half period lasts the programmed count; the compare uses >= so a
  // smaller value cuts the running half period short at once.
  always_comb begin
    cnt_d = cnt_q;
    slow_d = slow_q;
    slow_derived_clock_d = slow_derived_clock_q;
    tick_d = 1'b0;
    if (d.slow_div == 6'h00 || cnt_q >= d.slow_div - 6'h01) begin
      cnt_d = 6'h00;
      slow_d = !slow_q;
      if (!slow_q) begin
        slow_derived_clock_d = !slow_derived_clock_q;
        tick_d = !slow_derived_clock_q;
      end
    end else begin
      cnt_d = cnt_q + 6'h01;
    end
  end

  // Divider state registers.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_q <= 6'h00;
      slow_q <= 1'b0;
      slow_derived_clock_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      slow_q <= slow_d;
      slow_derived_clock_q <= slow_derived_clock_d;
      tick_q <= tick_d;
    end
  end

  // Divider outputs.
  assign d.slow_level = slow_q;
  assign d.slow_derived_clock_level = slow_derived_clock_q;
  assign d.slow_derived_clock_tick = tick_q & ce_i;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_SLOW_BYPASS: assert property (ce_i && d.slow_div == 6'h00 |=>
    slow_q != $past(slow_q)) else $error("bypassed slow clock stalled");
endmodule : pcg_slow_div

// ---- rtl/pcg_exit_ctl.sv ----
// STOP and pseudo-STOP entry and exit sequencing.
`timescale 1ns/100ps
module pcg_exit_ctl
  import pcg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  pcg_if.exitc e
);
  pcg_exit_t st_q, st_d;
  logic [12:0] cnt_q, cnt_d;
  logic [12:0] tgt_q, tgt_d;
  logic pstop_q, pstop_d;
  logic limp_q, limp_d;
  logic cmr_q, cmr_d;

  // Next state of the stop sequencer.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    tgt_d = tgt_q;
    pstop_d = pstop_q;
    limp_d = 1'b0;
    cmr_d = 1'b0;
    unique case (st_q)
      PCG_EX_RUN: begin
        if (e.stop_req && e.no_limp && e.clock_monitor_enable) begin
          cmr_d = 1'b1;
        end else if (e.stop_req) begin
          st_d = PCG_EX_STOP;
          pstop_d = e.pstop_en;
        end
      end
      PCG_EX_STOP: begin
        if (e.wake) begin
          cnt_d = 13'h0000;
          limp_d = !e.no_limp;
          if (e.dly) begin
            st_d = PCG_EX_DELAY;
            tgt_d = EXIT_LONG_SLOW_DERIVED_CLOCK;
          end else if (e.no_limp) begin
            st_d = PCG_EX_DELAY;
            tgt_d = EXIT_SHORT_SLOW_DERIVED_CLOCK;
          end else begin
            st_d = PCG_EX_RUN;
          end
        end
      end
      PCG_EX_DELAY: begin
        if (e.slow_derived_clock_tick) begin
          cnt_d = cnt_q + 13'h0001;
          if (cnt_q == tgt_q - 13'h0001) begin
            st_d = PCG_EX_RUN;
          end
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q <= PCG_EX_RUN;
      cnt_q <= 13'h0000;
      tgt_q <= 13'h0000;
      pstop_q <= 1'b0;
      limp_q <= 1'b0;
      cmr_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tgt_q <= tgt_d;
      pstop_q <= pstop_d;
      limp_q <= limp_d;
      cmr_q <= cmr_d;
    end
  end

  // The oscillator stops in plain STOP only.
  assign e.held = (st_q != PCG_EX_RUN);
  assign e.osc_run = (st_q != PCG_EX_STOP) || pstop_q;
  assign e.limp_enter = limp_q & ce_i;
  assign e.cm_reset = cmr_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_PSTOP_OSC: assert property (st_q == PCG_EX_STOP && pstop_q |->
    e.osc_run && e.held) else $error("pseudo stop lost oscillator");
  AST_EXIT_DELAY: assert property (ce_i && st_q == PCG_EX_STOP && e.wake
    && e.dly |=> st_q == PCG_EX_DELAY && tgt_q == 13'h1000)
    else $error("delayed exit did not wait");
endmodule : pcg_exit_ctl

// ---- rtl/pcg_top.sv ----
// PLL clock generator control: registers, limp-home, selects, stop exit.
// Notes on behaviour
// - Multiplier and divider writes blocked under PLL select.
// - PLL multiplier applied is value plus one.
// - Reference division is divider value plus one.
// - Any STOP exit with no-limp clear enters limp-home mode.
// - Lock change sets flag; write-one and limp clear.
// - Lock status read-only, zero during limp-home.
// - Limp entry or exit sets limp flag.
// - Limp status shows reference clock loss.
// - PLL-on uncleareable under PLL select; forced in limp.
// - Supply low forces enables off, no-limp on.
// - Auto bandwidth picks band; acquisition bit read-only.
// - Manual bandwidth: zero high, one low.
// - Pseudo-STOP keeps oscillator running while stopped.
// - Limp interrupt only with its enable set.
// - Clock loss: limp-home, or monitor reset.
// - No-limp bit write-once in normal modes.
// - PLL select needs PLL on; forced in limp.
// - Slow select chooses slow or oscillator clock.
// - Module clock select, forced to peripheral in limp.
// - Slow divider is twice value, zero bypasses.
// - Slow clock even duty, further halved.
// - Unassisted delayed exit waits 4096 derived cycles.
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
module pcg_top
  import pcg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pll_lock_i,
  input wire logic ref_clock_lost_i,
  input wire logic pll_supply_ok_i,
  input wire logic vco_near_target_i,
  input wire logic wake_i,
  input wire logic stop_req_i,
  input wire logic clock_monitor_enable_i,
  input wire logic stop_exit_delay_i,
  input wire logic special_mode_i,
  output logic pll_power_on_o,
  output logic [8:0] pll_mult_o,
  output logic [8:0] pll_ref_div_o,
  output logic pll_low_bw_o,
  output pcg_src_t system_clock_src_o,
  output logic module_clock_select_o,
  output logic slow_clock_o,
  output logic slow_derived_clock_o,
  output logic clock_monitor_reset_o,
  output logic chip_stopped_o,
  output logic osc_run_o,
  output logic limp_status_o,
  output logic lock_irq_o,
  output logic limp_irq_o
);
  pcg_if bus ();

  // Pin synchronisers: lock, loss, supply, near target, wake.
  logic [4:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic lock_s, lost_s, supply_s, near_s, wake_s;

  // Register file and status state.
  logic [7:0] ctrl_q, ctrl_d;
  logic nolimp_wr_q, nolimp_wr_d;
  logic [7:0] sel_q, sel_d;
  logic [5:0] slow_q, slow_d;
  logic [7:0] mult_q, mult_d;
  logic [7:0] refdiv_q, refdiv_d;
  logic lock_chg_q, lock_chg_d;
  logic lock_stat_q, lock_stat_d;
  logic limp_chg_q, limp_chg_d;
  logic limp_q, limp_d;
  logic [12:0] lcnt_q, lcnt_d;
  logic lost_q, lost_d;
  logic cmr_q, cmr_d;
  logic [8:0] pmult_q, pmult_d;
  logic [8:0] pref_q, pref_d;
  logic [31:0] rd_q, rd_d;

  // APB decode helpers.
  logic addr_ok, hit_mult, hit_ref, hit_flg, hit_ctrl, hit_sel, hit_slow;
  logic wr_en, lock_stat, bus_clock_pll_select_eff;
  logic [7:0] wd, flags_rd, ctrl_rd, rd_byte;

  // First stage feeds only the second stage.
  always_comb begin
    sync1_d = {wake_i, vco_near_target_i, pll_supply_ok_i, ref_clock_lost_i,
      pll_lock_i};
    sync2_d = sync1_q;
  end

  // Synchroniser flops.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_q <= 5'h04;
      sync2_q <= 5'h04;
    end else if (ce_i) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // Synchronised pin levels.
  assign lock_s = sync2_q[0];
  assign lost_s = sync2_q[1];
  assign supply_s = sync2_q[2];
  assign near_s = sync2_q[3];
  assign wake_s = sync2_q[4];

  // Address decode; the access phase always completes at once.
  assign addr_ok = (paddr_i[1:0] == 2'b00);
  assign hit_mult = addr_ok && paddr_i[9:2] == IDX_LOOP_MULT;
  assign hit_ref = addr_ok && paddr_i[9:2] == IDX_REF_DIV;
  assign hit_flg = addr_ok && paddr_i[9:2] == IDX_FLAGS;
  assign hit_ctrl = addr_ok && paddr_i[9:2] == IDX_PLL_CTRL;
  assign hit_sel = addr_ok && paddr_i[9:2] == IDX_CLK_SEL;
  assign hit_slow = addr_ok && paddr_i[9:2] == IDX_SLOW_DIV;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !(hit_mult || hit_ref ||
    hit_flg || hit_ctrl || hit_sel || hit_slow);
  assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0] && !pslverr_o;
  assign wd = pwdata_i[7:0];

  // Lock reads zero in limp-home since the detector has no reference.
  assign lock_stat = lock_s && !limp_q;
  assign bus_clock_pll_select_eff = sel_q[SEL_BUS_CLOCK_PLL_SELECT] || limp_q;

  // Readback of pll_control shows bandwidth status under automatic control.
  always_comb begin
    ctrl_rd = ctrl_q;
    ctrl_rd[3] = 1'b0;
    if (ctrl_q[CTL_AUTO]) begin
      ctrl_rd[CTL_ACQ] = near_s;
    end
    flags_rd = 8'h00;
    flags_rd[FLG_LOCK_CHG] = lock_chg_q;
    flags_rd[FLG_LOCK] = lock_stat;
    flags_rd[FLG_LIMP_CHG] = limp_chg_q;
    flags_rd[FLG_LIMP] = limp_q;
  end

  // Next values of the control, select, slow divider, multiplier and divider registers.
  always_comb begin
    ctrl_d = ctrl_q;
    nolimp_wr_d = nolimp_wr_q;
    sel_d = sel_q;
    slow_d = slow_q;
    mult_d = mult_q;
    refdiv_d = refdiv_q;
    if (wr_en && hit_ctrl) begin
      ctrl_d[CTL_LOCK_IE] = wd[CTL_LOCK_IE];
      ctrl_d[CTL_AUTO] = wd[CTL_AUTO];
      ctrl_d[CTL_PSTOP] = wd[CTL_PSTOP];
      ctrl_d[CTL_LIMP_IE] = wd[CTL_LIMP_IE];
      if (!ctrl_q[CTL_AUTO]) begin
        ctrl_d[CTL_ACQ] = wd[CTL_ACQ];
      end
      if (wd[CTL_PLL_ON] || !sel_q[SEL_BUS_CLOCK_PLL_SELECT]) begin
        ctrl_d[CTL_PLL_ON] = wd[CTL_PLL_ON];
      end
      if (special_mode_i || !nolimp_wr_q) begin
        ctrl_d[CTL_NO_LIMP] = wd[CTL_NO_LIMP];
        nolimp_wr_d = 1'b1;
      end
    end
    if (!supply_s) begin
      ctrl_d[CTL_LOCK_IE] = 1'b0;
      ctrl_d[CTL_PLL_ON] = 1'b0;
      ctrl_d[CTL_LIMP_IE] = 1'b0;
      ctrl_d[CTL_NO_LIMP] = 1'b1;
    end
    if (wr_en && hit_sel) begin
      sel_d[SEL_BUS_CLOCK_PLL_SELECT] = wd[SEL_BUS_CLOCK_PLL_SELECT] && ctrl_q[CTL_PLL_ON];
      sel_d[SEL_BUS_CLOCK_SLOW_SELECT] = wd[SEL_BUS_CLOCK_SLOW_SELECT];
      sel_d[SEL_MCS] = wd[SEL_MCS];
    end
    if (wr_en && hit_slow) begin
      slow_d = wd[5:0];
    end
    if (wr_en && hit_mult && !sel_q[SEL_BUS_CLOCK_PLL_SELECT]) begin
      mult_d = wd;
    end
    if (wr_en && hit_ref && !sel_q[SEL_BUS_CLOCK_PLL_SELECT]) begin
      refdiv_d = wd;
    end
  end

  // Software-visible registers.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_q <= PLL_CTRL_RST;
      nolimp_wr_q <= 1'b0;
      sel_q <= CLK_SEL_RST;
      slow_q <= SLOW_DIV_RST;
      mult_q <= LOOP_MULT_RST;
      refdiv_q <= REF_DIV_RST;
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
      nolimp_wr_q <= nolimp_wr_d;
      sel_q <= sel_d;
      slow_q <= slow_d;
      mult_q <= mult_d;
      refdiv_q <= refdiv_d;
    end
  end

  // Limp-home entry, periodic clock check, flags and monitor reset.
  always_comb begin
    limp_d = limp_q;
    lcnt_d = 13'h0000;
    lost_d = lost_s;
    if (limp_q) begin
      lcnt_d = lcnt_q;
      if (bus.slow_derived_clock_tick) begin
        lcnt_d = lcnt_q + 13'h0001;
        if (lcnt_q == LIMP_CHECK_SLOW_DERIVED_CLOCK - 13'h0001) begin
          lcnt_d = 13'h0000;
          limp_d = lost_s;
        end
      end
    end else if ((lost_s && !ctrl_q[CTL_NO_LIMP]) || bus.limp_enter) begin
      limp_d = 1'b1;
    end
    cmr_d = (lost_s && !lost_q && ctrl_q[CTL_NO_LIMP]) || bus.cm_reset;
    lock_stat_d = lock_stat;
    // A new event wins over the write-one clear.
    lock_chg_d = (lock_stat != lock_stat_q) ||
      (lock_chg_q && !(wr_en && hit_flg && wd[FLG_LOCK_CHG]));
    if (limp_q) begin
      lock_chg_d = 1'b0;
    end
    limp_chg_d = (limp_d != limp_q) ||
      (limp_chg_q && !(wr_en && hit_flg && wd[FLG_LIMP_CHG]));
    pmult_d = {1'b0, mult_q} + 9'h001;
    pref_d = {1'b0, refdiv_q} + 9'h001;
  end

  // Status and derived output registers.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      limp_q <= 1'b0;
      lcnt_q <= 13'h0000;
      lost_q <= 1'b0;
      cmr_q <= 1'b0;
      lock_stat_q <= 1'b0;
      lock_chg_q <= 1'b0;
      limp_chg_q <= 1'b0;
      pmult_q <= 9'h001;
      pref_q <= 9'h001;
    end else if (ce_i) begin
      limp_q <= limp_d;
      lcnt_q <= lcnt_d;
      lost_q <= lost_d;
      cmr_q <= cmr_d;
      lock_stat_q <= lock_stat_d;
      lock_chg_q <= lock_chg_d;
      limp_chg_q <= limp_chg_d;
      pmult_q <= pmult_d;
      pref_q <= pref_d;
    end
  end

  // Read data is captured in the setup phase.
  always_comb begin
    rd_byte = 8'h00;
    if (hit_mult) begin
      rd_byte = mult_q;
    end else if (hit_ref) begin
      rd_byte = refdiv_q;
    end else if (hit_flg) begin
      rd_byte = flags_rd;
    end else if (hit_ctrl) begin
      rd_byte = ctrl_rd;
    end else if (hit_sel) begin
      rd_byte = sel_q;
    end else if (hit_slow) begin
      rd_byte = {2'b00, slow_q};
    end
    rd_d = rd_q;
    if (psel_i && !penable_i && !pwrite_i) begin
      rd_d = {24'h000000, rd_byte};
    end
  end

  // Read data register.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_q <= 32'h00000000;
    end else if (ce_i) begin
      rd_q <= rd_d;
    end
  end

  // Carrier hookup to the slow divider and the stop sequencer.
  assign bus.slow_div = slow_q;
  assign bus.stop_req = stop_req_i;
  assign bus.pstop_en = ctrl_q[CTL_PSTOP];
  assign bus.wake = wake_s;
  assign bus.no_limp = ctrl_q[CTL_NO_LIMP];
  assign bus.clock_monitor_enable = clock_monitor_enable_i;
  assign bus.dly = stop_exit_delay_i;

  pcg_slow_div u_div (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d(bus.div)
  );

  pcg_exit_ctl u_exit (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .e(bus.exitc)
  );

  // Clock selection and forced outputs in limp-home.
  always_comb begin
    if (bus_clock_pll_select_eff) begin
      system_clock_src_o = PCG_SRC_PLL;
    end else if (sel_q[SEL_BUS_CLOCK_SLOW_SELECT]) begin
      system_clock_src_o = PCG_SRC_SLOW;
    end else begin
      system_clock_src_o = PCG_SRC_OSC;
    end
  end
  assign pll_power_on_o = ctrl_q[CTL_PLL_ON] || limp_q;
  assign module_clock_select_o = sel_q[SEL_MCS] && !limp_q;
  assign pll_low_bw_o = ctrl_q[CTL_AUTO] ? near_s : ctrl_q[CTL_ACQ];
  assign pll_mult_o = pmult_q;
  assign pll_ref_div_o = pref_q;
  assign slow_clock_o = bus.slow_level;
  assign slow_derived_clock_o = bus.slow_derived_clock_level;
  assign clock_monitor_reset_o = cmr_q;
  assign chip_stopped_o = bus.held;
  assign osc_run_o = bus.osc_run;
  assign limp_status_o = limp_q;
  assign lock_irq_o = lock_chg_q && ctrl_q[CTL_LOCK_IE];
  assign limp_irq_o = limp_chg_q && ctrl_q[CTL_LIMP_IE];
  assign prdata_o = rd_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_LOOP_LOCKED: assert property (ce_i && wr_en && hit_mult &&
    sel_q[SEL_BUS_CLOCK_PLL_SELECT] |=> mult_q == $past(mult_q))
    else $error("multiplier written under PLL select");
  AST_MULT_PLUS: assert property (ce_i |=>
    pll_mult_o == {1'b0, $past(mult_q)} + 9'h001)
    else $error("multiplier output not value plus one");
  AST_REFDIV_PLUS: assert property (ce_i |=>
    pll_ref_div_o == {1'b0, $past(refdiv_q)} + 9'h001)
    else $error("divider output not value plus one");
  AST_LOCK_FLAG: assert property (ce_i && !limp_q &&
    lock_stat != lock_stat_q |=> lock_chg_q)
    else $error("lock change not flagged");
  AST_LOCK_ZERO: assert property (limp_q |-> !flags_rd[FLG_LOCK])
    else $error("lock reads one in limp home");
  AST_LIMP_FLAG: assert property (ce_i && limp_d != limp_q |=>
    limp_chg_q) else $error("limp change not flagged");
  AST_PLL_FORCE: assert property (limp_q |-> pll_power_on_o &&
    system_clock_src_o == PCG_SRC_PLL) else $error("limp forcing missing");
  AST_SUPPLY_LOW: assert property (ce_i && !supply_s |=>
    !ctrl_q[CTL_LOCK_IE] && !ctrl_q[CTL_PLL_ON] && !ctrl_q[CTL_LIMP_IE]
    && ctrl_q[CTL_NO_LIMP]) else $error("supply low not forcing");
  AST_LIMP_IRQ: assert property (limp_irq_o |-> ctrl_q[CTL_LIMP_IE])
    else $error("limp interrupt without enable");
  AST_MCS_FORCE: assert property (limp_q |-> !module_clock_select_o)
    else $error("module select not forced in limp");
endmodule : pcg_top

// ---- sim/pcg_top_tb.sv ----
// Self-checking testbench of the PLL clock generator control block.
`timescale 1ns/100ps
module pcg_top_tb
  import pcg_pkg::*;
;
  logic clk, rst, psel, pen, pwr, lock, lost, sup, wake, stop, dly;
  logic pready, err, pon, lbw, module_clock_select, slw, stp, osc, limp, lk_irq, lh_irq;
  logic near, clock_monitor_enable, cmr, slow_derived_clock;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] mult, rdiv;
  pcg_src_t src;
  int fails, check_count;

  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  pcg_top pcg_top_inst (
    .sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(err), .pll_lock_i(lock), .ref_clock_lost_i(lost),
    .pll_supply_ok_i(sup), .vco_near_target_i(near), .wake_i(wake),
    .stop_req_i(stop), .clock_monitor_enable_i(clock_monitor_enable),
    .stop_exit_delay_i(dly), .special_mode_i(1'b0),
    .pll_power_on_o(pon), .pll_mult_o(mult), .pll_ref_div_o(rdiv),
    .pll_low_bw_o(lbw), .system_clock_src_o(src),
    .module_clock_select_o(module_clock_select), .slow_clock_o(slw),
    .slow_derived_clock_o(slow_derived_clock), .clock_monitor_reset_o(cmr),
    .chip_stopped_o(stp), .osc_run_o(osc), .limp_status_o(limp),
    .lock_irq_o(lk_irq), .limp_irq_o(lh_irq));

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Register write and checked register read.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic e;
    apb(1'b1, idx, d, e);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic e;
    apb(1'b0, idx, 8'h00, e);
    chk(rd, {24'h000000, exp});
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Reset values, and an unmapped address that must be refused.
  task automatic t_reset;
    logic e;
    rdc(IDX_PLL_CTRL, 8'h60);
    rdc(IDX_CLK_SEL, 8'h00);
    rdc(IDX_SLOW_DIV, 8'h00);
    rdc(IDX_LOOP_MULT, 8'h00);
    rdc(IDX_REF_DIV, 8'h00);
    rdc(IDX_FLAGS, 8'h00);
    apb(1'b0, 8'h00, 8'h00, e);
    chk({31'h0, e}, 32'h1);
    chk({23'h0, mult}, 32'h1);
    near <= 1'b1;
    cyc(4);
    chk({31'h0, lbw}, 32'h1);
    rdc(IDX_PLL_CTRL, 8'h70);
    near <= 1'b0;
    $display("test reset done");
  endtask : t_reset

  // Ratios, manual bandwidth, write-once no-limp bit, slow divider.
  task automatic t_ratio;
    logic s0;
    int n;
    wr(IDX_LOOP_MULT, 8'h05);
    wr(IDX_REF_DIV, 8'h02);
    cyc(2);
    chk({23'h0, mult}, 32'h6);
    chk({23'h0, rdiv}, 32'h3);
    wr(IDX_PLL_CTRL, 8'h42);
    cyc(2);
    chk({31'h0, lbw}, 32'h0);
    wr(IDX_PLL_CTRL, 8'h53);
    cyc(2);
    chk({31'h0, lbw}, 32'h1);
    rdc(IDX_PLL_CTRL, 8'h52);
    wr(IDX_SLOW_DIV, 8'h03);
    cyc(8);
    s0 = slw;
    while (slw === s0) @(posedge clk);
    s0 = slw;
    n = 0;
    while (slw === s0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(n, 32'h3);
    s0 = slow_derived_clock;
    while (slow_derived_clock === s0) @(posedge clk);
    s0 = slow_derived_clock;
    n = 0;
    while (slow_derived_clock === s0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(n, 32'h6);
    wr(IDX_SLOW_DIV, 8'h00);
    $display("test ratio done");
  endtask : t_ratio

  // Bus clock selection and the writes it blocks.
  task automatic t_select;
    wr(IDX_CLK_SEL, 8'h80);
    cyc(1);
    chk({30'h0, src}, {30'h0, PCG_SRC_PLL});
    wr(IDX_LOOP_MULT, 8'h09);
    rdc(IDX_LOOP_MULT, 8'h05);
    wr(IDX_PLL_CTRL, 8'h12);
    rdc(IDX_PLL_CTRL, 8'h52);
    wr(IDX_CLK_SEL, 8'h40);
    cyc(1);
    chk({30'h0, src}, {30'h0, PCG_SRC_SLOW});
    wr(IDX_PLL_CTRL, 8'h12);
    wr(IDX_CLK_SEL, 8'h80);
    rdc(IDX_CLK_SEL, 8'h00);
    wr(IDX_PLL_CTRL, 8'h52);
    $display("test select done");
  endtask : t_select

  // Lock change flag in both directions, its interrupt and clearing.
  task automatic t_lock;
    lock <= 1'b1;
    cyc(6);
    rdc(IDX_FLAGS, 8'hc0);
    wr(IDX_PLL_CTRL, 8'hd2);
    cyc(1);
    chk({31'h0, lk_irq}, 32'h1);
    wr(IDX_FLAGS, 8'h80);
    rdc(IDX_FLAGS, 8'h40);
    lock <= 1'b0;
    cyc(6);
    rdc(IDX_FLAGS, 8'h80);
    $display("test lock done");
  endtask : t_lock

  // Reference loss enters limp-home; recovery leaves it again.
  task automatic t_limp;
    int n;
    wr(IDX_CLK_SEL, 8'h01);
    lock <= 1'b1;
    lost <= 1'b1;
    cyc(6);
    chk({31'h0, limp}, 32'h1);
    chk({31'h0, lh_irq}, 32'h1);
    chk({31'h0, module_clock_select}, 32'h0);
    chk({30'h0, src}, {30'h0, PCG_SRC_PLL});
    chk({31'h0, pon}, 32'h1);
    rdc(IDX_FLAGS, 8'h03);
    rdc(IDX_CLK_SEL, 8'h01);
    wr(IDX_FLAGS, 8'h02);
    rdc(IDX_FLAGS, 8'h01);
    lost <= 1'b0;
    n = 0;
    while (limp !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    rdc(IDX_FLAGS, 8'hc2);
    wr(IDX_PLL_CTRL, 8'h50);
    cyc(1);
    chk({31'h0, lh_irq}, 32'h0);
    wr(IDX_FLAGS, 8'h82);
    $display("test limp done");
  endtask : t_limp

  // Waits for the monitor reset pulse and checks that it lasts one cycle.
  task automatic cmr_pulse;
    int n;
    n = 0;
    while (cmr !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, cmr}, 32'h1);
    @(posedge clk);
    chk({31'h0, cmr}, 32'h0);
  endtask : cmr_pulse

  // Stops with a stop pulse, then holds wake; count cycles of the delayed exit.
  task automatic stop_wake(input logic exp_limp, output int n);
    stop <= 1'b1;
    cyc(1);
    stop <= 1'b0;
    cyc(3);
    chk({31'h0, stp}, 32'h1);
    chk({31'h0, osc}, 32'h1);
    wake <= 1'b1;
    n = 0;
    while (stp !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
      if (n == 6) chk({31'h0, limp}, {31'h0, exp_limp});
    end
    wake <= 1'b0;
    chk({31'h0, stp}, 32'h0);
  endtask : stop_wake

  // Pseudo-STOP exits, first into limp-home, then after supply loss.
  task automatic t_stop;
    int n;
    dly <= 1'b1;
    wr(IDX_PLL_CTRL, 8'h54);
    stop_wake(1'b1, n);
    while (limp !== 1'b0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    sup <= 1'b0;
    cyc(6);
    rdc(IDX_PLL_CTRL, 8'h15);
    stop_wake(1'b0, n);
    chk({31'h0, n >= 16384 && n <= 16420}, 32'h1);
    clock_monitor_enable <= 1'b1;
    stop <= 1'b1;
    cyc(1);
    stop <= 1'b0;
    cmr_pulse;
    chk({31'h0, stp}, 32'h0);
    clock_monitor_enable <= 1'b0;
    lost <= 1'b1;
    cmr_pulse;
    chk({31'h0, limp}, 32'h0);
    lost <= 1'b0;
    $display("test stop done");
  endtask : t_stop

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Main sequence.
  initial begin
    fails = 0;
    check_count = 0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    lock = 1'b0;
    lost = 1'b0;
    sup = 1'b1;
    wake = 1'b0;
    stop = 1'b0;
    dly = 1'b0;
    near = 1'b0;
    clock_monitor_enable = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    t_reset;
    t_ratio;
    t_select;
    t_lock;
    t_limp;
    t_stop;
    summarize;
  end

  // Watchdog that cuts a hang short.
  initial begin
    repeat (99000) @(posedge clk);
    fails++;
    summarize;
  end
endmodule : pcg_top_tb
